// ### rtl/cpu_core_register_state.sv
`timescale 1ns/1ns
module cpu_core_register_state (
  input  wire logic        ref_clk_i,
  input  wire logic        rst_n_i,
  input  wire logic [7:0]  awaddr_i,
  input  wire logic        awvalid_i,
  output logic             awready_o,
  input  wire logic [31:0] wdata_i,
  input  wire logic [3:0]  wstrb_i,
  input  wire logic        wvalid_i,
  output logic             wready_o,
  output logic [1:0]       bresp_o,
  output logic             bvalid_o,
  input  wire logic        bready_i,
  input  wire logic [7:0]  araddr_i,
  input  wire logic        arvalid_i,
  output logic             arready_o,
  output logic [31:0]      rdata_o,
  output logic [1:0]       rresp_o,
  output logic             rvalid_o,
  input  wire logic        rready_i
);
  logic [15:0]           ip_q;
  logic [15:0]           wp_q;
  logic [15:0]           sw_q;
  logic [15:0]           opa_q;
  logic [15:0]           opb_q;
  logic [15:0]           result_q;
  logic [15:0]           addr_q;
  logic [4:0]            info_q;
  cpu_state_pkg::cmd_op_t op_q;
  logic                  byte_q;
  logic [3:0]            n_q;
  logic                  go_q;
  logic [7:0]            awaddr_q;
  logic                  aw_have_q;
  logic [31:0]           wdata_q;
  logic [3:0]            wstrb_q;
  logic                  w_have_q;
  logic                  wr_do;
  logic                  wr_hit;
  logic [15:0]           wr_val;
  logic [31:0]           rd_val;
  logic                  rd_hit;
  logic [15:0]           f_result;
  logic                  f_lgt;
  logic                  f_agt;
  logic                  f_eq;
  logic                  f_carry;
  logic                  f_ovf;
  logic                  f_par;
  logic [15:0]           jump_ofs;
  logic [15:0]           reg_addr;
  logic [15:0]           trap_addr;
  logic [15:0]           irq_addr;
  logic                  irq_ok;

  status_flag_unit u_flags (
    .byte_i   (byte_q),
    .op_i     (op_q),
    .a_i      (opa_q),
    .b_i      (opb_q),
    .cnt_i    (n_q),
    .result_o (f_result),
    .lgt_o    (f_lgt),
    .agt_o    (f_agt),
    .eq_o     (f_eq),
    .carry_o  (f_carry),
    .ovf_o    (f_ovf),
    .par_o    (f_par)
  );

  // Write address and data are taken independently, then joined
  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_n_i)
    begin
      aw_have_q <= 1'b0;
      w_have_q  <= 1'b0;
      awaddr_q  <= 8'h00;
      wdata_q   <= 32'h0000_0000;
      wstrb_q   <= 4'h0;
    end
    else
    begin
      if (awvalid_i && awready_o)
      begin
        aw_have_q <= 1'b1;
        awaddr_q  <= awaddr_i;
      end
      else if (wr_do)
        aw_have_q <= 1'b0;
      if (wvalid_i && wready_o)
      begin
        w_have_q <= 1'b1;
        wdata_q  <= wdata_i;
        wstrb_q  <= wstrb_i;
      end
      else if (wr_do)
        w_have_q <= 1'b0;
    end
  end

  assign wr_do = aw_have_q && w_have_q && !bvalid_o;

  // Ready only while the channel's holding slot is empty
  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_n_i)
    begin
      awready_o <= 1'b0;
      wready_o  <= 1'b0;
    end
    else
    begin
      awready_o <= !aw_have_q && !(awvalid_i && awready_o);
      wready_o  <= !w_have_q && !(wvalid_i && wready_o);
    end
  end

  // Writable registers decode; low half of the word is masked by strobe, unstrobed bytes written as zero
  always_comb
  begin
    wr_val[7:0]  = wstrb_q[0] ? wdata_q[7:0] : 8'h00;
    wr_val[15:8] = wstrb_q[1] ? wdata_q[15:8] : 8'h00;
    unique case (awaddr_q)
      cpu_state_pkg::IP_OFF,
      cpu_state_pkg::WP_OFF,
      cpu_state_pkg::SW_OFF,
      cpu_state_pkg::OPA_OFF,
      cpu_state_pkg::OPB_OFF,
      cpu_state_pkg::CMD_OFF: wr_hit = 1'b1;
      default:                wr_hit = 1'b0;
    endcase
  end

  // Write response
  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_n_i)
    begin
      bvalid_o <= 1'b0;
      bresp_o  <= cpu_state_pkg::RESP_OKAY;
    end
    else if (wr_do)
    begin
      bvalid_o <= 1'b1;
      bresp_o  <= wr_hit ? cpu_state_pkg::RESP_OKAY
                         : cpu_state_pkg::RESP_SLVERR;
    end
    else if (bready_i)
      bvalid_o <= 1'b0;
  end

  // Operand and command registers; a command write starts one operation
  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_n_i)
    begin
      opa_q  <= 16'h0000;
      opb_q  <= 16'h0000;
      op_q   <= cpu_state_pkg::OP_IDLE;
      byte_q <= 1'b0;
      n_q    <= 4'h0;
      go_q   <= 1'b0;
    end
    else
    begin
      go_q <= 1'b0;
      if (wr_do && awaddr_q == cpu_state_pkg::OPA_OFF)
        opa_q <= wr_val;
      if (wr_do && awaddr_q == cpu_state_pkg::OPB_OFF)
        opb_q <= wr_val;
      if (wr_do && awaddr_q == cpu_state_pkg::CMD_OFF)
      begin
        op_q   <= cpu_state_pkg::cmd_op_t'(wr_val[cpu_state_pkg::CMD_OP_HI:0]);
        byte_q <= wr_val[cpu_state_pkg::CMD_BYTE];
        n_q    <= wr_val[cpu_state_pkg::CMD_N_HI:cpu_state_pkg::CMD_N_LO];
        go_q   <= 1'b1;
      end
    end
  end

  // Address arithmetic for workspace, jumps and vectors
  always_comb
  begin
    reg_addr = wp_q + {11'h000, n_q, 1'b0};
    // Signed 8-bit word displacement: -128..+127 words from the word after the jump
    jump_ofs = {{7{opa_q[7]}}, opa_q[7:0], 1'b0};
    trap_addr = cpu_state_pkg::TRAP_VEC_BASE + {10'h000, n_q, 2'b00};
    irq_addr = {10'h000, n_q, 2'b00};
    // Level 0 is highest; a level above the mask is ignored
    irq_ok = n_q <= sw_q[cpu_state_pkg::MASK_HI:cpu_state_pkg::MASK_LO];
  end

  // Instruction pointer: fetch step, relative jump, or software load
  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_n_i)
      ip_q <= cpu_state_pkg::IP_RESET;
    else if (wr_do && awaddr_q == cpu_state_pkg::IP_OFF)
      ip_q <= wr_val;
    else if (go_q && op_q == cpu_state_pkg::OP_FETCH)
      ip_q <= ip_q + cpu_state_pkg::IP_STEP;
    else if (go_q && op_q == cpu_state_pkg::OP_JUMP)
      ip_q <= ip_q + jump_ofs;
  end

  // Workspace base pointer
  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_n_i)
      wp_q <= cpu_state_pkg::WP_RESET;
    else if (wr_do && awaddr_q == cpu_state_pkg::WP_OFF)
      wp_q <= wr_val;
  end

  // Status word flags from operations
  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_n_i)
      sw_q <= cpu_state_pkg::SW_RESET;
    else if (wr_do && awaddr_q == cpu_state_pkg::SW_OFF)
      sw_q <= wr_val;
    else if (go_q)
    begin
      unique case (op_q)
        cpu_state_pkg::OP_COMPARE:
        begin
          sw_q[cpu_state_pkg::SW_LGT] <= f_lgt;
          sw_q[cpu_state_pkg::SW_AGT] <= f_agt;
          sw_q[cpu_state_pkg::SW_EQ]  <= f_eq;
          if (byte_q)
            sw_q[cpu_state_pkg::SW_OP] <= f_par;
        end
        cpu_state_pkg::OP_ADD,
        cpu_state_pkg::OP_SUB:
        begin
          sw_q[cpu_state_pkg::SW_C]  <= f_carry;
          sw_q[cpu_state_pkg::SW_OV] <= f_ovf;
          if (byte_q)
            sw_q[cpu_state_pkg::SW_OP] <= f_par;
        end
        cpu_state_pkg::OP_SHIFT_LEFT,
        cpu_state_pkg::OP_SHIFT_RIGHT:
          sw_q[cpu_state_pkg::SW_C] <= f_carry;
        cpu_state_pkg::OP_TRAP:
          sw_q[cpu_state_pkg::SW_X] <= 1'b1;
        default:
          sw_q <= sw_q;
      endcase
    end
  end

  // Result, computed address and decode flags
  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_n_i)
    begin
      result_q <= 16'h0000;
      addr_q   <= 16'h0000;
      info_q   <= 5'h00;
    end
    else if (go_q)
    begin
      result_q <= f_result;
      unique case (op_q)
        cpu_state_pkg::OP_FETCH:
        begin
          addr_q <= ip_q;
          // Jump to next word decodes as no_operation
          info_q[cpu_state_pkg::INFO_NO_OPERATION] <=
            opa_q == cpu_state_pkg::NO_OPERATION_CODE;
        end
        cpu_state_pkg::OP_REG_ADDR: addr_q <= reg_addr;
        cpu_state_pkg::OP_JUMP:     addr_q <= ip_q + jump_ofs;
        cpu_state_pkg::OP_TRAP:     addr_q <= trap_addr;
        cpu_state_pkg::OP_IRQ:
        begin
          addr_q <= irq_addr;
          info_q[cpu_state_pkg::INFO_IRQ_ACC] <= irq_ok;
        end
        default: addr_q <= addr_q;
      endcase
    end
    else
    begin
      // Odd or above-top addresses are flagged as errors
      info_q[cpu_state_pkg::INFO_ADDR_ERR] <=
        addr_q[0] || addr_q > cpu_state_pkg::MAX_WORD;
      info_q[cpu_state_pkg::INFO_IP_ERR] <=
        ip_q[0] || ip_q > cpu_state_pkg::MAX_WORD;
      info_q[cpu_state_pkg::INFO_VECTOR] <=
        addr_q <= cpu_state_pkg::VECTOR_TOP;
    end
  end

  // Read mux
  always_comb
  begin
    rd_hit = 1'b1;
    unique case (araddr_i)
      cpu_state_pkg::IP_OFF:     rd_val = {16'h0000, ip_q};
      cpu_state_pkg::WP_OFF:     rd_val = {16'h0000, wp_q};
      cpu_state_pkg::SW_OFF:     rd_val = {16'h0000, sw_q};
      cpu_state_pkg::OPA_OFF:    rd_val = {16'h0000, opa_q};
      cpu_state_pkg::OPB_OFF:    rd_val = {16'h0000, opb_q};
      cpu_state_pkg::CMD_OFF:
        rd_val = {20'h00000, n_q, 3'h0, byte_q, 4'(op_q)};
      cpu_state_pkg::RESULT_OFF: rd_val = {16'h0000, result_q};
      cpu_state_pkg::ADDR_OFF:   rd_val = {16'h0000, addr_q};
      cpu_state_pkg::INFO_OFF:   rd_val = {27'h0000000, info_q};
      default:
      begin
        rd_val = 32'h0000_0000;
        rd_hit = 1'b0;
      end
    endcase
  end

  // Read channel: one read at a time, data registered
  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_n_i)
    begin
      arready_o <= 1'b0;
      rvalid_o  <= 1'b0;
      rdata_o   <= 32'h0000_0000;
      rresp_o   <= cpu_state_pkg::RESP_OKAY;
    end
    else if (arvalid_i && arready_o)
    begin
      arready_o <= 1'b0;
      rvalid_o  <= 1'b1;
      rdata_o   <= rd_val;
      rresp_o   <= rd_hit ? cpu_state_pkg::RESP_OKAY
                          : cpu_state_pkg::RESP_SLVERR;
    end
    else if (rvalid_o)
    begin
      if (rready_i)
      begin
        rvalid_o  <= 1'b0;
        arready_o <= 1'b1;
      end
    end
    else
      arready_o <= 1'b1;
  end
endmodule

// ### rtl/cpu_state_pkg.sv
package cpu_state_pkg;

  // Register byte offsets on the bus
  localparam logic [7:0] IP_OFF     = 8'h00;
  localparam logic [7:0] WP_OFF     = 8'h04;
  localparam logic [7:0] SW_OFF     = 8'h08;
  localparam logic [7:0] OPA_OFF    = 8'h0c;
  localparam logic [7:0] OPB_OFF    = 8'h10;
  localparam logic [7:0] CMD_OFF    = 8'h14;
  localparam logic [7:0] RESULT_OFF = 8'h18;
  localparam logic [7:0] ADDR_OFF   = 8'h1c;
  localparam logic [7:0] INFO_OFF   = 8'h20;

  // Status word bit positions
  localparam int SW_LGT = 15;
  localparam int SW_AGT = 14;
  localparam int SW_EQ  = 13;
  localparam int SW_C   = 12;
  localparam int SW_OV  = 11;
  localparam int SW_OP  = 10;
  localparam int SW_X   = 9;
  localparam int MASK_HI = 3;
  localparam int MASK_LO = 0;

  // Command register fields
  localparam int CMD_OP_HI = 3;
  localparam int CMD_BYTE  = 4;
  localparam int CMD_N_HI  = 11;
  localparam int CMD_N_LO  = 8;

  // Info register bit positions
  localparam int INFO_ADDR_ERR = 0;
  localparam int INFO_VECTOR   = 1;
  localparam int INFO_NO_OPERATION = 2;
  localparam int INFO_IP_ERR   = 3;
  localparam int INFO_IRQ_ACC  = 4;

  // Reset values and memory constants
  localparam logic [15:0] IP_RESET          = 16'h0000;
  localparam logic [15:0] WP_RESET          = 16'h0000;
  localparam logic [15:0] SW_RESET          = 16'h0000;
  localparam logic [15:0] IP_STEP           = 16'h0002;
  localparam logic [15:0] NO_OPERATION_CODE = 16'h1000;
  localparam logic [15:0] MAX_WORD          = 16'h3ffe;
  localparam logic [15:0] VECTOR_TOP        = 16'h007f;
  localparam logic [15:0] TRAP_VEC_BASE     = 16'h0040;
  localparam logic [1:0]  RESP_OKAY         = 2'b00;
  localparam logic [1:0]  RESP_SLVERR       = 2'b10;

  // Operations started by a command write
  typedef enum logic [3:0] {
    OP_FETCH,
    OP_REG_ADDR,
    OP_COMPARE,
    OP_ADD,
    OP_SUB,
    OP_SHIFT_LEFT,
    OP_SHIFT_RIGHT,
    OP_JUMP,
    OP_TRAP,
    OP_IRQ,
    OP_IDLE
  } cmd_op_t;

endpackage

// ### rtl/status_flag_unit.sv
`timescale 1ns/1ns
// Computes result and status flags for one operation on A (dest), B (source)
module status_flag_unit (
  input  wire logic                 byte_i,
  input  wire cpu_state_pkg::cmd_op_t op_i,
  input  wire logic [15:0]          a_i,
  input  wire logic [15:0]          b_i,
  input  wire logic [3:0]           cnt_i,
  output logic      [15:0]          result_o,
  output logic                      lgt_o,
  output logic                      agt_o,
  output logic                      eq_o,
  output logic                      carry_o,
  output logic                      ovf_o,
  output logic                      par_o
);
  logic [15:0] ua;
  logic [15:0] ub;
  logic [16:0] sum;
  logic [16:0] dif;
  logic [16:0] shl;
  logic [16:0] shr;
  logic        msb_a;
  logic        msb_b;
  logic        msb_r;

  // Byte operands live in the high byte and are aligned to the word MSB
  always_comb
  begin
    ua = byte_i ? {a_i[15:8], 8'h00} : a_i;
    ub = byte_i ? {b_i[15:8], 8'h00} : b_i;
    sum = {1'b0, ua} + {1'b0, ub};
    dif = {1'b0, ua} + {1'b0, ~ub} + 17'h00001;
    shl = {1'b0, a_i} << cnt_i;
    shr = {a_i, 1'b0} >> cnt_i;
    msb_a = ua[15];
    msb_b = ub[15];
    result_o = a_i;
    carry_o = 1'b0;
    ovf_o = 1'b0;
    unique case (op_i)
      cpu_state_pkg::OP_ADD:
      begin
        result_o = byte_i ? {sum[15:8], a_i[7:0]} : sum[15:0];
        carry_o = sum[16];
      end
      cpu_state_pkg::OP_SUB:
      begin
        result_o = byte_i ? {dif[15:8], a_i[7:0]} : dif[15:0];
        carry_o = dif[16];
      end
      cpu_state_pkg::OP_SHIFT_LEFT:
      begin
        result_o = shl[15:0];
        carry_o = shl[16];
      end
      cpu_state_pkg::OP_SHIFT_RIGHT:
      begin
        result_o = shr[16:1];
        carry_o = shr[0];
      end
      default:
      begin
        result_o = a_i;
      end
    endcase
    msb_r = result_o[15];
    if (op_i == cpu_state_pkg::OP_ADD)
      ovf_o = (msb_a == msb_b) && (msb_r != msb_a);
    else if (op_i == cpu_state_pkg::OP_SUB)
      ovf_o = (msb_a != msb_b) && (msb_r != msb_a);
    // Unsigned compare: MSB weighs 32768 (word) or 128 (byte)
    lgt_o = ua > ub;
    // Signed compare: MSB is the sign
    agt_o = $signed(ua) > $signed(ub);
    eq_o  = ua == ub;
    par_o = ^result_o[15:8];
  end
endmodule

// ### testbench/cpu_core_register_state_properties.sv
`timescale 1ns/1ns
module cpu_core_register_state_properties (
  input wire logic        ref_clk_i,
  input wire logic        rst_n_i,
  input wire logic [7:0]  awaddr_i,
  input wire logic        awvalid_i,
  input wire logic        awready_o,
  input wire logic [31:0] wdata_i,
  input wire logic [3:0]  wstrb_i,
  input wire logic        wvalid_i,
  input wire logic        wready_o,
  input wire logic [1:0]  bresp_o,
  input wire logic        bvalid_o,
  input wire logic        bready_i,
  input wire logic [7:0]  araddr_i,
  input wire logic        arvalid_i,
  input wire logic        arready_o,
  input wire logic [31:0] rdata_o,
  input wire logic [1:0]  rresp_o,
  input wire logic        rvalid_o,
  input wire logic        rready_i
);
  // One clock domain, synchronous active-low reset
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!rst_n_i);

  property p_b_hold;
    bvalid_o && !bready_i |=> bvalid_o;
  endproperty
  a_b_hold: assert property (p_b_hold)
    else $error("write response dropped early");
  property p_w_resp;
    awvalid_i && awready_o && wvalid_i && wready_o |-> ##[1:2] bvalid_o;
  endproperty
  a_w_resp: assert property (p_w_resp)
    else $error("write response late");
  property p_w_busy;
    bvalid_o |-> !awready_o && !wready_o;
  endproperty
  a_w_busy: assert property (p_w_busy)
    else $error("write slot open during response");
  property p_r_hold;
    rvalid_o && !rready_i |=> rvalid_o && $stable(rdata_o) && $stable(rresp_o);
  endproperty
  a_r_hold: assert property (p_r_hold)
    else $error("read data changed before taken");
  property p_r_lat;
    arvalid_i && arready_o |=> rvalid_o;
  endproperty
  a_r_lat: assert property (p_r_lat)
    else $error("read answer late");
  property p_r_drop;
    rvalid_o && rready_i |=> !rvalid_o;
  endproperty
  a_r_drop: assert property (p_r_drop)
    else $error("read answer repeated");
  property p_r_busy;
    rvalid_o |-> !arready_o;
  endproperty
  a_r_busy: assert property (p_r_busy)
    else $error("read slot open during answer");
  property p_upper;
    rvalid_o |-> rdata_o[31:16] == 16'h0000;
  endproperty
  a_upper: assert property (p_upper)
    else $error("read data above word width");
  property p_unmap;
    arvalid_i && arready_o && araddr_i > 8'h20 |=>
      rresp_o == cpu_state_pkg::RESP_SLVERR && rdata_o == 32'h00000000;
  endproperty
  a_unmap: assert property (p_unmap)
    else $error("unmapped read not refused");
  // Main traffic kinds
  c_write: cover property (bvalid_o && bready_i);
  c_read: cover property (rvalid_o && rready_i);
  c_err: cover property (rvalid_o && rresp_o == cpu_state_pkg::RESP_SLVERR);
endmodule

bind cpu_core_register_state cpu_core_register_state_properties u_props (.*);

// ### testbench/mem_model.sv
`timescale 1ns/1ns
// Word memory seen from the processor bus, byte addressed
module mem_model (
  input  wire logic        clk_i,
  input  wire logic [15:0] addr_i,
  input  wire logic [15:0] wdata_i,
  input  wire logic        we_i,
  output logic      [15:0] rdata_o,
  output logic             err_o
);
  logic [15:0] mem_q [0:8191];
  logic [15:0] last_q;

  // Odd or out-of-range addresses are not words
  assign err_o = addr_i[0] | (addr_i > cpu_state_pkg::MAX_WORD);

  // Even-aligned 16-bit word store
  always_ff @(posedge clk_i)
  begin
    if (we_i && !err_o)
      mem_q[addr_i[13:1]] <= wdata_i;
    if (!err_o)
      last_q <= mem_q[addr_i[13:1]];
  end

  // No word answers a bad address, so the bus shows junk
  assign rdata_o = err_o ? ~last_q : mem_q[addr_i[13:1]];
endmodule

// ### testbench/tb_cpu_core_register_state.sv
`timescale 1ns/1ns
module tb_cpu_core_register_state;
  logic        ref_clk_i, rst_n_i;
  logic [7:0]  awaddr_i, araddr_i;
  logic        awvalid_i, wvalid_i, bready_i, arvalid_i, rready_i;
  logic [31:0] wdata_i, rdata_o;
  logic [3:0]  wstrb_i;
  logic        awready_o, wready_o, bvalid_o, arready_o, rvalid_o;
  logic [1:0]  bresp_o, rresp_o, r;
  logic [15:0] mem_addr, mem_wdata, mem_rdata, ip, wp, a, b, v;
  logic        mem_we, mem_err;
  logic [18:0] e;
  logic [7:0]  disp [3];
  int          num_errors, total_checks, cycles, n, k;

  cpu_core_register_state u_cpu_core_register_state (.*);
  mem_model u_mem_model (.clk_i(ref_clk_i), .addr_i(mem_addr),
    .wdata_i(mem_wdata), .we_i(mem_we), .rdata_o(mem_rdata),
    .err_o(mem_err));

  // Clock and hang guard
  initial
  begin
    ref_clk_i = 1'b0;
    forever #2 ref_clk_i = ~ref_clk_i;
  end
  always @(posedge ref_clk_i)
  begin
    cycles <= cycles + 1;
    if (cycles == 30000)
    begin
      num_errors++;
      wrap_up();
    end
  end

  task automatic chk(input string s, input logic [15:0] x, y);
    total_checks++;
    if (y !== x)
    begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", s, x, y);
    end
  endtask

  task automatic wr(input logic [7:0] ad, input logic [15:0] d);
    @(posedge ref_clk_i);
    awaddr_i <= ad;
    wdata_i <= {16'h0000, d};
    wstrb_i <= 4'hf;
    awvalid_i <= 1'b1;
    wvalid_i <= 1'b1;
    bready_i <= 1'b1;
    do
    begin
      @(posedge ref_clk_i);
      if (awready_o) awvalid_i <= 1'b0;
      if (wready_o) wvalid_i <= 1'b0;
    end while (!bvalid_o);
    r = bresp_o;
    bready_i <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] ad, output logic [15:0] d);
    @(posedge ref_clk_i);
    araddr_i <= ad;
    arvalid_i <= 1'b1;
    rready_i <= 1'b1;
    do
    begin
      @(posedge ref_clk_i);
      if (arready_o) arvalid_i <= 1'b0;
    end while (!rvalid_o);
    d = rdata_o[15:0];
    r = rresp_o;
    rready_i <= 1'b0;
  endtask

  task automatic op(input cpu_state_pkg::cmd_op_t c, input logic bt,
                    input logic [3:0] cnt);
    wr(cpu_state_pkg::CMD_OFF, {4'h0, cnt, 3'h0, bt, c});
  endtask

  // Expected LGT, AGT, EQ; byte operands sit in the high byte
  function automatic logic [2:0] exp_cmp(input logic [15:0] x, y,
                                         input logic bt);
    if (bt)
    begin
      x[7:0] = 8'h00;
      y[7:0] = 8'h00;
    end
    return {x > y, $signed(x) > $signed(y), x == y};
  endfunction

  // Expected subtract: {no borrow, overflow, odd parity, raw difference}
  function automatic logic [18:0] exp_sub(input logic [15:0] x, y,
                                          input logic bt);
    logic [15:0] d;
    if (bt)
    begin
      x[7:0] = 8'h00;
      y[7:0] = 8'h00;
    end
    d = x - y;
    return {x >= y, x[15] != y[15] && d[15] != x[15], ^d[15:8], d};
  endfunction

  task wrap_up;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // Main sequence
  initial
  begin
    {awaddr_i, araddr_i, wdata_i, wstrb_i} = '0;
    {awvalid_i, wvalid_i, bready_i, arvalid_i, rready_i} = '0;
    {mem_addr, mem_wdata, mem_we, rst_n_i} = '0;
    {num_errors, total_checks, cycles} = '0;
    disp = '{8'h7f, 8'h80, 8'h00};
    n = $urandom(32'hf578);
    repeat (20) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    rd(cpu_state_pkg::IP_OFF, v);
    chk("ip_rst", cpu_state_pkg::IP_RESET, v);
    rd(cpu_state_pkg::WP_OFF, v);
    chk("wp_rst", cpu_state_pkg::WP_RESET, v);
    rd(cpu_state_pkg::SW_OFF, v);
    chk("sw_rst", cpu_state_pkg::SW_RESET, v);
    rd(8'h24, v);
    chk("unmap_rd", {14'h0, cpu_state_pkg::RESP_SLVERR}, {14'h0, r});
    wr(cpu_state_pkg::RESULT_OFF, 16'h1234);
    chk("ro_wr", {14'h0, cpu_state_pkg::RESP_SLVERR}, {14'h0, r});
    for (n = 0; n < 6; n++)
    begin
      // Last pass fetches the top word, so the pointer runs past the end
      ip = (n == 5) ? cpu_state_pkg::MAX_WORD
                    : 16'({$urandom_range(0, 8191), 1'b0});
      @(posedge ref_clk_i);
      mem_addr <= ip;
      mem_wdata <= n[0] ? cpu_state_pkg::NO_OPERATION_CODE : 16'($urandom);
      mem_we <= 1'b1;
      @(posedge ref_clk_i);
      mem_we <= 1'b0;
      @(posedge ref_clk_i);
      a = mem_rdata;
      wr(cpu_state_pkg::IP_OFF, ip);
      wr(cpu_state_pkg::OPA_OFF, a);
      op(cpu_state_pkg::OP_FETCH, 1'b0, 4'h0);
      rd(cpu_state_pkg::IP_OFF, v);
      chk("ip_step", ip + 16'h0002, v);
      rd(cpu_state_pkg::ADDR_OFF, v);
      chk("fetch_addr", ip, v);
      rd(cpu_state_pkg::INFO_OFF, v);
      chk("no_op", {15'h0, a == 16'h1000}, {15'h0, v[2]});
      chk("ip_err", {15'h0, n == 5}, {15'h0, v[3]});
    end
    wp = 16'({$urandom_range(0, 8000), 1'b0});
    wr(cpu_state_pkg::WP_OFF, wp);
    for (k = 0; k < 16; k++)
    begin
      op(cpu_state_pkg::OP_REG_ADDR, 1'b0, k[3:0]);
      rd(cpu_state_pkg::ADDR_OFF, v);
      chk("reg_addr", wp + 16'(2 * k), v);
    end
    wr(cpu_state_pkg::WP_OFF, 16'h3ffe);
    op(cpu_state_pkg::OP_REG_ADDR, 1'b0, 4'h1);
    rd(cpu_state_pkg::INFO_OFF, v);
    chk("addr_err", 16'h0001, {15'h0, v[0]});
    for (n = 0; n < 8; n++)
    begin
      a = 16'($urandom);
      b = (n < 2) ? a : 16'($urandom);
      wr(cpu_state_pkg::OPA_OFF, a);
      wr(cpu_state_pkg::OPB_OFF, b);
      op(cpu_state_pkg::OP_COMPARE, n[0], 4'h0);
      rd(cpu_state_pkg::SW_OFF, v);
      chk("cmp", {13'h0, exp_cmp(a, b, n[0])},
          {13'h0, v[15:13]});
      op(cpu_state_pkg::OP_ADD, 1'b0, 4'h0);
      rd(cpu_state_pkg::RESULT_OFF, v);
      chk("sum", a + b, v);
      rd(cpu_state_pkg::SW_OFF, v);
      chk("add_c", {15'h0, 17'(a) + 17'(b) > 17'h0ffff},
          {15'h0, v[12]});
      // Subtract in word and byte form: result, carry, overflow; parity in byte form
      e = exp_sub(a, b, n[0]);
      op(cpu_state_pkg::OP_SUB, n[0], 4'h0);
      rd(cpu_state_pkg::RESULT_OFF, v);
      chk("diff", n[0] ? {e[15:8], a[7:0]} : e[15:0], v);
      rd(cpu_state_pkg::SW_OFF, v);
      chk("sub_c_ov", {14'h0, e[18:17]}, {14'h0, v[12:11]});
      if (n[0])
        chk("par", {15'h0, e[16]}, {15'h0, v[10]});
      k = $urandom_range(1, 15);
      op(cpu_state_pkg::OP_SHIFT_RIGHT, 1'b0, k[3:0]);
      rd(cpu_state_pkg::SW_OFF, v);
      chk("shr_c", {15'h0, a[k - 1]}, {15'h0, v[12]});
      op(cpu_state_pkg::OP_SHIFT_LEFT, 1'b0, k[3:0]);
      rd(cpu_state_pkg::SW_OFF, v);
      chk("shl_c", {15'h0, a[16 - k]}, {15'h0, v[12]});
    end
    // Jump word sits at 1ffe; the pointer already reads 2000 when it runs
    for (n = 0; n < 3; n++)
    begin
      wr(cpu_state_pkg::IP_OFF, 16'h2000);
      wr(cpu_state_pkg::OPA_OFF, {8'h10, disp[n]});
      op(cpu_state_pkg::OP_JUMP, 1'b0, 4'h0);
      rd(cpu_state_pkg::IP_OFF, v);
      chk("jump",
          16'(32'sh1ffe + 2 + 2 * int'($signed(disp[n]))), v);
    end
    for (k = 0; k < 16; k += 15)
    begin
      op(cpu_state_pkg::OP_TRAP, 1'b0, k[3:0]);
      rd(cpu_state_pkg::ADDR_OFF, v);
      chk("vec", 16'h0040 + 16'(4 * k), v);
      rd(cpu_state_pkg::SW_OFF, v);
      chk("trap_flag", 16'h0001, {15'h0, v[9]});
      rd(cpu_state_pkg::INFO_OFF, v);
      chk("vec_area", 16'h0001, {15'h0, v[1]});
    end
    wp = 16'($urandom_range(0, 15));
    wr(cpu_state_pkg::SW_OFF, wp);
    for (k = 0; k < 16; k++)
    begin
      op(cpu_state_pkg::OP_IRQ, 1'b0, k[3:0]);
      rd(cpu_state_pkg::INFO_OFF, v);
      chk("irq_acc", {15'h0, k <= wp}, {15'h0, v[4]});
    end
    wrap_up();
  end
endmodule
